// ---- core/insn_decode_pkg.sv ----
package insn_decode_pkg;

   // instruction formats, as reported on fmt_out
   typedef enum logic [2:0] {
      FMT_RR  = 3'h0,
      FMT_RX  = 3'h1,
      FMT_RS  = 3'h2,
      FMT_SI  = 3'h3,
      FMT_SS1 = 3'h4,
      FMT_SS2 = 3'h5
   } fmt_t;

   // fetch position; gray codes along first -> second -> third
   typedef enum logic [1:0] {
      ST_FIRST  = 2'h0,
      ST_SECOND = 2'h1,
      ST_THIRD  = 2'h3
   } fetch_state_t;

   localparam int HW_W   = 16;
   localparam int ADDR_W = 32;
   localparam int REG_W  = 32;
   localparam int NREGS  = 16;
   localparam int DISP_W = 12;
   localparam int LEN_W  = 9;
   localparam int CYC_W  = 10;

   // halfword counts
   localparam logic [1:0] ILEN_ONE   = 2'h1;
   localparam logic [1:0] ILEN_TWO   = 2'h2;
   localparam logic [1:0] ILEN_THREE = 2'h3;

   // field positions inside a halfword (instruction bit 0 is msb)
   localparam int OPC_HI  = 15;  // bits 0-7
   localparam int OPC_LO  = 8;
   localparam int FA_HI   = 7;   // bits 8-11, first halfword only
   localparam int FA_LO   = 4;
   localparam int FB_HI   = 3;   // bits 12-15
   localparam int FB_LO   = 0;
   localparam int BASE_HI = 15;  // base nibble of an address halfword
   localparam int BASE_LO = 12;
   localparam int DISP_HI = 11;
   localparam int DISP_LO = 0;

   // opcode classes: op[7:6], then op[3] or op[4] to split
   localparam logic [1:0] OPC_CLS_RR  = 2'h0;
   localparam logic [1:0] OPC_CLS_RX  = 2'h1;
   localparam logic [1:0] OPC_CLS_RSI = 2'h2;
   localparam int         OPC_SI_BIT = 3;
   localparam int         OPC_SS_BIT = 4;

   // execution cycle estimates
   localparam logic [CYC_W-1:0] CYC_RR      = 10'h001;
   localparam logic [CYC_W-1:0] CYC_TWO_HW  = 10'h002;
   localparam logic [CYC_W-1:0] CYC_SS_BASE = 10'h002;

   // encoded length field holds byte count minus one
   localparam logic [LEN_W-1:0] LEN_BIAS = 9'h001;

endpackage

// ---- core/operand_addr_adder.sv ----
`timescale 1ns/100ps
module operand_addr_adder (
   // operand parts
   input  wire logic [insn_decode_pkg::REG_W-1:0]  base_val_in,
   input  wire logic [insn_decode_pkg::REG_W-1:0]  index_val_in,
   input  wire logic [insn_decode_pkg::DISP_W-1:0] disp_in,
   // effective address, wraps modulo 2**ADDR_W
   output logic      [insn_decode_pkg::ADDR_W-1:0] addr_out
);
   logic [insn_decode_pkg::ADDR_W-1:0] disp_ext;

   assign disp_ext = {{(insn_decode_pkg::ADDR_W-insn_decode_pkg::DISP_W){1'b0}},
                      disp_in};
   assign addr_out = base_val_in + index_val_in + disp_ext;
endmodule

// ---- core/instruction_format_decoder.sv ----
`timescale 1ns/100ps
// Behaviour
// - register-register instructions are one halfword; the next starts right after.
// - register-indexed, multiregister-storage and immediate forms are two halfwords.
// - both storage-to-storage forms are three halfwords, all fetched before decode.
// - opcode is bits 0-7; rest of first halfword depends on format.
// - second halfword addresses operand 2 (RX, RS) or operand 1 (SI, SS).
// - third halfword is always operand 2 base (32-35) and displacement (36-47).
// - register-register takes operand 1 reg from 8-11, operand 2 from 12-15.
// - register-indexed takes index register number from bits 12-15.
// - multireg-storage takes first group reg 8-11, last group reg 12-15.
// - immediate format takes bits 8-15 as operand 2 immediate byte.
// - equal-length storage form takes one 8-bit length from bits 8-15.
// - unequal-length form takes operand 1 length 8-11, operand 2 12-15.
// - second-halfword address: base from bits 16-19, displacement from 20-31.
// - data flows from operand 2 to operand 1; result overwrites operand 1.
// - storage forms take cycles growing with length; register form fastest.
// - storage address equals base register contents plus displacement, plus index register contents in the register-indexed form.
// - equal-length storage operands are at most 256 bytes.
// - unequal-length storage operands are at most 16 bytes each.
module instruction_format_decoder (
   // clock and reset
   input  wire logic                                ref_clk_in,
   input  wire logic                                sys_rst_in,
   // halfword stream from fetch
   input  wire logic                                hw_valid_in,
   input  wire logic [insn_decode_pkg::HW_W-1:0]    hw_data_in,
   output logic                                     hw_ready_out,
   // general register write port
   input  wire logic                                gpr_wr_en_in,
   input  wire logic [3:0]                          gpr_wr_idx_in,
   input  wire logic [insn_decode_pkg::REG_W-1:0]   gpr_wr_data_in,
   // decoded instruction
   output logic                                     dec_valid_out,
   output logic [2:0]                               fmt_out,
   output logic [1:0]                               ilen_hw_out,
   output logic [7:0]                               opcode_out,
   output logic [3:0]                               first_operand_reg_field_out,
   output logic [3:0]                               second_operand_reg_field_out,
   output logic [3:0]                               group_last_reg_field_out,
   output logic [3:0]                               index_reg_field_out,
   output logic [7:0]                               immediate_byte_field_out,
   output logic [insn_decode_pkg::LEN_W-1:0]        first_operand_length_out,
   output logic [insn_decode_pkg::LEN_W-1:0]        second_operand_length_out,
   output logic [3:0]                               first_base_field_out,
   output logic [insn_decode_pkg::DISP_W-1:0]       first_displacement_out,
   output logic [3:0]                               second_base_field_out,
   output logic [insn_decode_pkg::DISP_W-1:0]       second_displacement_out,
   output logic [insn_decode_pkg::ADDR_W-1:0]       op1_addr_out,
   output logic [insn_decode_pkg::ADDR_W-1:0]       op2_addr_out,
   output logic [insn_decode_pkg::CYC_W-1:0]        exec_cycles_out,
   output logic                                     op1_is_dest_out
);
   localparam int W = insn_decode_pkg::HW_W;
   localparam int A = insn_decode_pkg::ADDR_W;
   localparam int L = insn_decode_pkg::LEN_W;
   localparam int C = insn_decode_pkg::CYC_W;
   localparam int R = insn_decode_pkg::REG_W;
   localparam int D = insn_decode_pkg::DISP_W;

   // format from opcode only; no later halfword is looked at
   function automatic insn_decode_pkg::fmt_t fmt_of(input logic [7:0] op);
      insn_decode_pkg::fmt_t f;
      f = insn_decode_pkg::FMT_RR;
      if (op[7:6] == insn_decode_pkg::OPC_CLS_RR)
         f = insn_decode_pkg::FMT_RR;
      else if (op[7:6] == insn_decode_pkg::OPC_CLS_RX)
         f = insn_decode_pkg::FMT_RX;
      else if (op[7:6] == insn_decode_pkg::OPC_CLS_RSI)
         f = op[insn_decode_pkg::OPC_SI_BIT] ? insn_decode_pkg::FMT_SI
                                             : insn_decode_pkg::FMT_RS;
      else
         f = op[insn_decode_pkg::OPC_SS_BIT] ? insn_decode_pkg::FMT_SS2
                                             : insn_decode_pkg::FMT_SS1;
      return f;
   endfunction

   function automatic logic [1:0] ilen_of(input insn_decode_pkg::fmt_t f);
      logic [1:0] n;
      n = insn_decode_pkg::ILEN_TWO;
      if (f == insn_decode_pkg::FMT_RR)
         n = insn_decode_pkg::ILEN_ONE;
      else if (f == insn_decode_pkg::FMT_SS1 || f == insn_decode_pkg::FMT_SS2)
         n = insn_decode_pkg::ILEN_THREE;
      return n;
   endfunction

   // general registers for address formation
   logic [R-1:0] gpr_q [insn_decode_pkg::NREGS];

   insn_decode_pkg::fetch_state_t state_q, state_d;
   logic [W-1:0] hw1_q;
   logic [W-1:0] hw2_q;

   logic                  take;
   logic [W-1:0]          cur1;
   logic [W-1:0]          cur2;
   logic [7:0]            opc;
   insn_decode_pkg::fmt_t fmt;
   logic [1:0]            ilen;
   logic                  last_hw;
   logic                  is_rr, is_rx, is_rs, is_si, is_ss1, is_ss2, is_ss;
   logic [3:0]            nib_a, nib_b;
   logic [3:0]            b_second, b_third;
   logic [D-1:0]          d_second, d_third;
   logic [L-1:0]          len1, len2;
   logic [C-1:0]          cycles;
   logic [A-1:0]          addr_second, addr_third;
   logic [R-1:0]          idx_val;

   assign take    = hw_valid_in & hw_ready_out;
   assign cur1    = (state_q == insn_decode_pkg::ST_FIRST) ? hw_data_in : hw1_q;
   assign cur2    = (state_q == insn_decode_pkg::ST_SECOND) ? hw_data_in : hw2_q;
   assign opc     = cur1[insn_decode_pkg::OPC_HI:insn_decode_pkg::OPC_LO];
   assign fmt     = fmt_of(opc);
   assign ilen    = ilen_of(fmt);
   assign is_rr   = fmt == insn_decode_pkg::FMT_RR;
   assign is_rx   = fmt == insn_decode_pkg::FMT_RX;
   assign is_rs   = fmt == insn_decode_pkg::FMT_RS;
   assign is_si   = fmt == insn_decode_pkg::FMT_SI;
   assign is_ss1  = fmt == insn_decode_pkg::FMT_SS1;
   assign is_ss2  = fmt == insn_decode_pkg::FMT_SS2;
   assign is_ss   = is_ss1 | is_ss2;

   // the instruction completes on the halfword that matches its length
   assign last_hw = take & (
      (state_q == insn_decode_pkg::ST_FIRST  && ilen == insn_decode_pkg::ILEN_ONE) ||
      (state_q == insn_decode_pkg::ST_SECOND && ilen == insn_decode_pkg::ILEN_TWO) ||
      (state_q == insn_decode_pkg::ST_THIRD));

   assign nib_a    = cur1[insn_decode_pkg::FA_HI:insn_decode_pkg::FA_LO];
   assign nib_b    = cur1[insn_decode_pkg::FB_HI:insn_decode_pkg::FB_LO];
   assign b_second = cur2[insn_decode_pkg::BASE_HI:insn_decode_pkg::BASE_LO];
   assign d_second = cur2[insn_decode_pkg::DISP_HI:insn_decode_pkg::DISP_LO];
   assign b_third  = hw_data_in[insn_decode_pkg::BASE_HI:insn_decode_pkg::BASE_LO];
   assign d_third  = hw_data_in[insn_decode_pkg::DISP_HI:insn_decode_pkg::DISP_LO];

   // byte counts: 8-bit field gives up to 256, nibbles up to 16
   assign len1 = is_ss1 ? {1'b0, cur1[7:0]} + insn_decode_pkg::LEN_BIAS
               : is_ss2 ? {5'h00, nib_a} + insn_decode_pkg::LEN_BIAS
               : {L{1'b0}};
   assign len2 = is_ss1 ? len1
               : is_ss2 ? {5'h00, nib_b} + insn_decode_pkg::LEN_BIAS
               : {L{1'b0}};

   // cost grows with bytes moved; register form is the cheapest
   assign cycles = is_rr ? insn_decode_pkg::CYC_RR
                 : is_ss ? insn_decode_pkg::CYC_SS_BASE
                           + {1'b0, len1} + (is_ss2 ? {1'b0, len2} : {C{1'b0}})
                 : insn_decode_pkg::CYC_TWO_HW;

   // index only applies to the register-indexed form
   assign idx_val = is_rx ? gpr_q[nib_b] : {R{1'b0}};

   operand_addr_adder u_addr_second (
      .base_val_in  (gpr_q[b_second]),
      .index_val_in (idx_val),
      .disp_in      (d_second),
      .addr_out     (addr_second)
   );

   operand_addr_adder u_addr_third (
      .base_val_in  (gpr_q[b_third]),
      .index_val_in ({R{1'b0}}),
      .disp_in      (d_third),
      .addr_out     (addr_third)
   );

   always_comb begin
      state_d = state_q;
      if (last_hw)
         state_d = insn_decode_pkg::ST_FIRST;
      else if (take && state_q == insn_decode_pkg::ST_FIRST)
         state_d = insn_decode_pkg::ST_SECOND;
      else if (take && state_q == insn_decode_pkg::ST_SECOND)
         state_d = insn_decode_pkg::ST_THIRD;
   end

   // register contents are read before a same-cycle write lands
   always_ff @(posedge ref_clk_in) begin
      if (gpr_wr_en_in)
         gpr_q[gpr_wr_idx_in] <= gpr_wr_data_in;
   end

   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state_q      <= insn_decode_pkg::ST_FIRST;
         hw1_q        <= '0;
         hw2_q        <= '0;
         hw_ready_out <= 1'b0;
      end else begin
         state_q      <= state_d;
         hw_ready_out <= 1'b1;
         if (take && state_q == insn_decode_pkg::ST_FIRST)
            hw1_q <= hw_data_in;
         if (take && state_q == insn_decode_pkg::ST_SECOND)
            hw2_q <= hw_data_in;
      end
   end

   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         dec_valid_out <= 1'b0;
      end else begin
         dec_valid_out <= last_hw;
      end
   end

   // fields hold until the next instruction completes
   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         fmt_out                      <= '0;
         ilen_hw_out                  <= '0;
         opcode_out                   <= '0;
         first_operand_reg_field_out  <= '0;
         second_operand_reg_field_out <= '0;
         group_last_reg_field_out     <= '0;
         index_reg_field_out          <= '0;
         immediate_byte_field_out     <= '0;
         first_operand_length_out     <= '0;
         second_operand_length_out    <= '0;
         first_base_field_out         <= '0;
         first_displacement_out       <= '0;
         second_base_field_out        <= '0;
         second_displacement_out      <= '0;
         op1_addr_out                 <= '0;
         op2_addr_out                 <= '0;
         exec_cycles_out              <= '0;
         op1_is_dest_out              <= 1'b0;
      end else if (last_hw) begin
         fmt_out                      <= fmt;
         ilen_hw_out                  <= ilen;
         opcode_out                   <= opc;
         first_operand_reg_field_out  <= (is_rr | is_rx | is_rs) ? nib_a : 4'h0;
         second_operand_reg_field_out <= is_rr ? nib_b : 4'h0;
         group_last_reg_field_out     <= is_rs ? nib_b : 4'h0;
         index_reg_field_out          <= is_rx ? nib_b : 4'h0;
         immediate_byte_field_out     <= is_si ? cur1[7:0] : 8'h00;
         first_operand_length_out     <= len1;
         second_operand_length_out    <= len2;
         first_base_field_out         <= (is_si | is_ss) ? b_second : 4'h0;
         first_displacement_out       <= (is_si | is_ss) ? d_second : '0;
         second_base_field_out        <= (is_rx | is_rs) ? b_second
                                       : is_ss ? b_third : 4'h0;
         second_displacement_out      <= (is_rx | is_rs) ? d_second
                                       : is_ss ? d_third : '0;
         op1_addr_out                 <= (is_si | is_ss) ? addr_second : '0;
         op2_addr_out                 <= (is_rx | is_rs) ? addr_second
                                       : is_ss ? addr_third : '0;
         exec_cycles_out              <= cycles;
         op1_is_dest_out              <= 1'b1;
      end
   end
endmodule

// ---- tb/ifd_sva.sv ----
`timescale 1ns/100ps
module ifd_sva (
   // clock, reset and halfword stream
   input wire logic        ref_clk_in,
   input wire logic        sys_rst_in,
   input wire logic        hw_valid_in,
   input wire logic [15:0] hw_data_in,
   input wire logic        hw_ready_out,
   // decoded instruction
   input wire logic        dec_valid_out,
   input wire logic [2:0]  fmt_out,
   input wire logic [1:0]  ilen_hw_out,
   input wire logic [7:0]  opcode_out,
   input wire logic [8:0]  first_operand_length_out,
   input wire logic [8:0]  second_operand_length_out,
   input wire logic [3:0]  first_base_field_out,
   input wire logic [11:0] first_displacement_out,
   input wire logic [3:0]  second_base_field_out,
   input wire logic [11:0] second_displacement_out
);
   logic [15:0] h1_q;
   logic [15:0] h2_q;
   logic [15:0] h3_q;
   logic [1:0]  pos_q;
   logic [1:0]  len_q;
   logic [2:0]  efmt;
   wire         take = hw_valid_in & hw_ready_out;
   wire  [1:0]  cls = h1_q[15:14];
   wire  [1:0]  ln = (hw_data_in[15:14] == 2'h0) ? 2'h1 :
                      (hw_data_in[15:14] == 2'h3) ? 2'h3 : 2'h2;
   // own halfword count from the opcode, so a wrong length shows as timing
   wire         last = take && ((pos_q == 2'h0 && ln == 2'h1) ||
                       (pos_q == 2'h1 && len_q == 2'h2) || pos_q == 2'h2);
   assign efmt = (cls == 2'h0) ? 3'h0 : (cls == 2'h1) ? 3'h1 :
                 (cls == 2'h2) ? (h1_q[11] ? 3'h3 : 3'h2) :
                 (h1_q[12] ? 3'h5 : 3'h4);

   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         pos_q <= 2'h0;
         len_q <= 2'h0;
         h1_q  <= 16'h0000;
         h2_q  <= 16'h0000;
         h3_q  <= 16'h0000;
      end else if (take) begin
         if (pos_q == 2'h0) begin
            h1_q  <= hw_data_in;
            len_q <= ln;
            pos_q <= (ln == 2'h1) ? 2'h0 : 2'h1;
         end else if (pos_q == 2'h1) begin
            h2_q  <= hw_data_in;
            pos_q <= (len_q == 2'h2) ? 2'h0 : 2'h2;
         end else begin
            h3_q  <= hw_data_in;
            pos_q <= 2'h0;
         end
      end
   end

   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);

   a_ready_up: assert property (!$past(sys_rst_in) |-> hw_ready_out)
      else $error("halfword ready low after reset");
   a_dec_on_last: assert property (last |=> dec_valid_out)
      else $error("no decode pulse after last halfword");
   a_no_early_dec: assert property (!last |=> !dec_valid_out)
      else $error("decode pulse without a last halfword");
   a_fmt_map: assert property (dec_valid_out |-> fmt_out == efmt)
      else $error("format differs from opcode class");
   a_len_map: assert property (dec_valid_out |-> ilen_hw_out ==
      (fmt_out == 3'h0 ? 2'h1 : fmt_out > 3'h3 ? 2'h3 : 2'h2))
      else $error("halfword count wrong for format");
   a_opcode_bits: assert property (dec_valid_out |->
      opcode_out == h1_q[15:8])
      else $error("opcode not first halfword bits");
   a_eq_len: assert property (dec_valid_out && fmt_out == 3'h4 |->
      first_operand_length_out == {1'b0, h1_q[7:0]} + 9'h001 &&
      second_operand_length_out == first_operand_length_out)
      else $error("equal length field wrong");
   a_uneq_len: assert property (dec_valid_out && fmt_out == 3'h5 |->
      first_operand_length_out == {5'h00, h1_q[7:4]} + 9'h001 &&
      second_operand_length_out == {5'h00, h1_q[3:0]} + 9'h001)
      else $error("unequal length fields wrong");
   a_op1_addr_hw: assert property (dec_valid_out && fmt_out > 3'h2 |->
      {first_base_field_out, first_displacement_out} == h2_q)
      else $error("operand 1 address fields wrong");
   a_op2_addr_hw: assert property (dec_valid_out && fmt_out != 3'h0 &&
      fmt_out != 3'h3 |-> {second_base_field_out, second_displacement_out}
      == (fmt_out > 3'h3 ? h3_q : h2_q))
      else $error("operand 2 address fields wrong");
endmodule

bind instruction_format_decoder ifd_sva u_sva (
   .ref_clk_in, .sys_rst_in, .hw_valid_in, .hw_data_in, .hw_ready_out,
   .dec_valid_out, .fmt_out, .ilen_hw_out, .opcode_out,
   .first_operand_length_out, .second_operand_length_out,
   .first_base_field_out, .first_displacement_out,
   .second_base_field_out, .second_displacement_out
);

// ---- tb/fetch_model.sv ----
`timescale 1ns/100ps
module fetch_model (
   // clock and handshake
   input  wire logic        clk_in,
   input  wire logic        hw_ready_in,
   output logic             hw_valid_out,
   output logic [15:0]      hw_data_out
);
   // offers that never saw ready; the bench treats any as a timeout
   int misses;

   initial begin
      misses       = 0;
      hw_valid_out = 1'b0;
      hw_data_out  = 16'h0000;
   end

   // offer one halfword and hold it until the edge that takes it
   task automatic put(input logic [15:0] d);
      int k;
      @(negedge clk_in);
      hw_valid_out <= 1'b1;
      hw_data_out  <= d;
      for (k = 0; k < 16; k++) begin
         @(posedge clk_in);
         if (hw_ready_in === 1'b1) break;
      end
      if (k == 16) misses++;
   endtask

   // released bus shows the inverse so stale data is never mistaken
   task automatic idle();
      @(negedge clk_in);
      hw_valid_out <= 1'b0;
      hw_data_out  <= ~hw_data_out;
   endtask
endmodule

// ---- tb/instruction_format_decoder_tb.sv ----
`timescale 1ns/100ps
module instruction_format_decoder_tb;
   logic        ref_clk_in, sys_rst_in, hw_valid_in, hw_ready_out;
   logic        gpr_wr_en_in, dec_valid_out, op1_is_dest_out;
   logic [15:0] hw_data_in;
   logic [3:0]  gpr_wr_idx_in, first_operand_reg_field_out;
   logic [3:0]  second_operand_reg_field_out, group_last_reg_field_out;
   logic [3:0]  index_reg_field_out, first_base_field_out;
   logic [3:0]  second_base_field_out;
   logic [31:0] gpr_wr_data_in, op1_addr_out, op2_addr_out;
   logic [11:0] first_displacement_out, second_displacement_out;
   logic [8:0]  first_operand_length_out, second_operand_length_out;
   logic [9:0]  exec_cycles_out;
   logic [7:0]  opcode_out, immediate_byte_field_out;
   logic [2:0]  fmt_out;
   logic [1:0]  ilen_hw_out;
   int          err_count, tests_run;

   instruction_format_decoder u_dut (
      .ref_clk_in, .sys_rst_in, .hw_valid_in, .hw_data_in, .hw_ready_out,
      .gpr_wr_en_in, .gpr_wr_idx_in, .gpr_wr_data_in, .dec_valid_out,
      .fmt_out, .ilen_hw_out, .opcode_out, .first_operand_reg_field_out,
      .second_operand_reg_field_out, .group_last_reg_field_out,
      .index_reg_field_out, .immediate_byte_field_out,
      .first_operand_length_out, .second_operand_length_out,
      .first_base_field_out, .first_displacement_out,
      .second_base_field_out, .second_displacement_out,
      .op1_addr_out, .op2_addr_out, .exec_cycles_out, .op1_is_dest_out);

   fetch_model u_fetch (.clk_in(ref_clk_in), .hw_ready_in(hw_ready_out),
      .hw_valid_out(hw_valid_in), .hw_data_out(hw_data_in));

   always #25 ref_clk_in = ~ref_clk_in;

   // register 15 overflows on purpose inside regv; no address sum in these checks wraps
   function automatic logic [31:0] regv(input int i);
      return 32'h1111_1111 * i + 32'h0000_0010;
   endfunction

   task automatic chk(input logic [47:0] g, input logic [47:0] e);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, g, e);
      end
   endtask

   task automatic conclude();
      $display("checks=%0d mismatches=%0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic t_reset();
      @(negedge ref_clk_in);
      sys_rst_in <= 1'b1;
      repeat (6) @(negedge ref_clk_in);
      chk({hw_ready_out, dec_valid_out, op1_is_dest_out, opcode_out}, 0);
      sys_rst_in <= 1'b0;
      @(negedge ref_clk_in);
      chk(hw_ready_out, 1'b1);
   endtask

   task automatic load_regs();
      for (int i = 0; i < 16; i++) begin
         @(negedge ref_clk_in);
         gpr_wr_en_in   <= 1'b1;
         gpr_wr_idx_in  <= i[3:0];
         gpr_wr_data_in <= regv(i);
      end
      @(negedge ref_clk_in);
      gpr_wr_en_in <= 1'b0;
   endtask

   // pulse must stand in the very cycle after the last halfword
   task automatic issue(input logic [47:0] ins, input int n);
      for (int k = 0; k < n; k++) u_fetch.put(ins[47-16*k -: 16]);
      u_fetch.idle();
      chk(dec_valid_out, 1'b1);
      chk(48'(u_fetch.misses), 48'h0);
      if (dec_valid_out !== 1'b1 || u_fetch.misses != 0) conclude();
   endtask

   task automatic t_rr();
      issue(48'h1A5C_0000_0000, 1);
      chk({fmt_out, ilen_hw_out, opcode_out}, {3'h0, 2'h1, 8'h1A});
      chk({first_operand_reg_field_out, second_operand_reg_field_out},
          8'h5C);
      chk({exec_cycles_out, op1_is_dest_out}, {10'h001, 1'b1});
   endtask

   task automatic t_rx();
      logic [31:0] e;
      issue(48'h5B3F_F123_0000, 2);
      chk({fmt_out, ilen_hw_out, index_reg_field_out}, {3'h1, 2'h2, 4'hF});
      e = regv(15) + regv(15) + 32'h0000_0123;
      chk(op2_addr_out, e);
      chk(exec_cycles_out, 10'h002);
   endtask

   task automatic t_rs_si();
      logic [31:0] e;
      issue(48'h9047_0ABC_0000, 2);
      chk({fmt_out, first_operand_reg_field_out, group_last_reg_field_out},
          {3'h2, 8'h47});
      e = regv(0) + 32'h0000_0ABC;
      chk(op2_addr_out, e);
      issue(48'h98A5_2FFF_0000, 2);
      chk({fmt_out, immediate_byte_field_out}, {3'h3, 8'hA5});
      e = regv(2) + 32'h0000_0FFF;
      chk(op1_addr_out, e);
   endtask

   task automatic t_ss();
      logic [31:0] e;
      issue(48'hC0FF_1001_E800, 3);
      chk({fmt_out, first_operand_length_out, second_operand_length_out},
          {3'h4, 9'h100, 9'h100});
      chk(exec_cycles_out, 10'h102);
      e = regv(14) + 32'h0000_0800;
      chk(op2_addr_out, e);
      issue(48'hD20F_1001_E800, 3);
      chk({fmt_out, first_operand_length_out, second_operand_length_out},
          {3'h5, 9'h001, 9'h010});
      chk(exec_cycles_out, 10'h013);
      e = regv(1) + 32'h0000_0001;
      chk(op1_addr_out, e);
   endtask

   task automatic t_b2b();
      u_fetch.put(16'h0012);
      issue(48'h0134_0000_0000, 1);
      chk({first_operand_reg_field_out, second_operand_reg_field_out},
          8'h34);
   endtask

   initial begin
      ref_clk_in     = 1'b0;
      sys_rst_in     = 1'b1;
      gpr_wr_en_in   = 1'b0;
      gpr_wr_idx_in  = 4'h0;
      gpr_wr_data_in = 32'h0000_0000;
      err_count      = 0;
      tests_run      = 0;
      t_reset();
      load_regs();
      t_rr();
      t_rx();
      t_rs_si();
      t_ss();
      t_b2b();
      t_reset();
      conclude();
   end
endmodule
